// ---- design/hold_judgment_logic.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE1: In peak-to-peak mode the largest and smallest samples are tracked while timing is off.
// RULE2: With end-of-window update, the timing rising edge shows max minus min and judges it.
// RULE3: With continuous update, the display is cleared when timing turns off.
// RULE4: With continuous update, every window sample recomputes, shows and judges max minus min.
// RULE5: With continuous update, the timing rising edge freezes display and criterion.
// RULE6: In hold mode, display and criterion stay unchanged while timing is on.
// RULE7: In hold mode, while timing is off the live value is shown and judged.
// RULE8: In hold mode, a window without HIGH or LOW leaves GO held after it ends.
// RULE9: In hold mode, a HIGH in the window latches and ignores later live values.
// RULE10: A latched HIGH stays on after the window until timing next turns off.
// RULE11: In hold mode, the live value at the timing rising edge is captured for display.
// RULE12: Held criterion and display are released when timing next turns off.
// RULE13: The reset input clears a latched HIGH.
// RULE14: A LOW in the window latches like HIGH and stays after the window.
// RULE15: The reset input clears a latched LOW.
// RULE16: Each window restarts the extreme trackers from its first sample.
// RULE17: Above upper gives HIGH, below lower gives LOW, else GO, one output at a time.
module hold_judgment_logic #(
    parameter int DATA_W = hold_pkg::DATA_W_DEF
) (
    input wire logic core_clk,                          // System clock, 200 MHz
    input wire logic rst_n,                             // Synchronous reset, active low
    input wire logic timing_in,                         // External timing input, high is on
    input wire logic reset_in,                          // External reset input, high clears
    input wire hold_pkg::mode_t detect_mode,            // Peak-to-peak or out-of-tolerance hold
    input wire hold_pkg::upd_t hold_update_select,      // End-of-window or continuous update
    input wire logic sample_valid,                      // Live sample strobe
    input wire logic signed [DATA_W-1:0] sample_value,  // Live detection value
    input wire logic signed [DATA_W:0] upper_setpoint,  // HIGH threshold
    input wire logic signed [DATA_W:0] lower_setpoint,  // LOW threshold
    output logic signed [DATA_W:0] display_value,       // Held or live display value
    output logic display_valid,                         // Low while the standby display shows
    output logic high_out,                              // HIGH criterion output
    output logic go_out,                                // GO criterion output
    output logic low_out                                // LOW criterion output
);
    import hold_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (DATA_W < DATA_W_MIN || DATA_W > DATA_W_MAX) begin : g_bad_width
        $error("hold_judgment_logic: DATA_W out of range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic timing_d;
        logic have_ext;
        logic latched;
        logic valid;
        logic signed [DATA_W-1:0] max_v;
        logic signed [DATA_W-1:0] min_v;
        logic signed [DATA_W:0] disp;
        logic high;
        logic go;
        logic low;
    } state_t;

    localparam state_t STATE_RST = '{
        timing_d: RST_TIMING,
        have_ext: RST_FLAG,
        latched: RST_FLAG,
        valid: RST_FLAG,
        max_v: '0,
        min_v: '0,
        disp: '0,
        high: RST_FLAG,
        go: RST_FLAG,
        low: RST_FLAG
    };

    state_t state_reg;
    state_t state_next;

    logic rise;
    logic fall;
    logic is_p2p;
    logic is_cont;
    logic signed [DATA_W-1:0] max_n;
    logic signed [DATA_W-1:0] min_n;
    logic signed [DATA_W:0] diff_n;
    logic signed [DATA_W:0] diff_hold;
    logic signed [DATA_W:0] sample_ext;

    judge_if #(.W(DATA_W + 1)) jif ();

    judge_unit u_judge (
        .jif(jif)
    );

    // ------------------------------------------------------------------
    // Timing edges and extremes
    // ------------------------------------------------------------------
    // Edges of the timing input against last cycle's level
    assign rise = timing_in & ~state_reg.timing_d;
    assign fall = ~timing_in & state_reg.timing_d;
    assign is_p2p = (detect_mode == MODE_P2P);
    assign is_cont = (hold_update_select == UPD_CONT);
    assign sample_ext = (DATA_W + 1)'(sample_value);

    // Extremes including the present sample; a new window starts afresh
    always_comb begin
        if (!state_reg.have_ext || fall) begin
            max_n = sample_value; // RULE16
            min_n = sample_value;
        end else begin
            max_n = (sample_value > state_reg.max_v) ? sample_value : state_reg.max_v;
            min_n = (sample_value < state_reg.min_v) ? sample_value : state_reg.min_v;
        end
    end

    // Peak-to-peak differences, one bit wider so they never overflow
    assign diff_n = (DATA_W + 1)'(max_n) - (DATA_W + 1)'(min_n);
    assign diff_hold = (DATA_W + 1)'(state_reg.max_v) - (DATA_W + 1)'(state_reg.min_v);

    // Comparator input: difference in peak-to-peak mode, live value otherwise
    always_comb begin
        if (!is_p2p) begin
            jif.value = sample_ext;
        end else if (timing_in) begin
            jif.value = diff_hold;
        end else begin
            jif.value = diff_n;
        end
        jif.upper = upper_setpoint;
        jif.lower = lower_setpoint;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.timing_d = timing_in;
        if (reset_in) begin
            // External reset drops every latch and returns to standby
            state_next.latched = 1'b0;
            state_next.have_ext = 1'b0;
            state_next.valid = 1'b0;
            state_next.disp = '0;
            state_next.high = 1'b0; // RULE13
            state_next.go = 1'b0;
            state_next.low = 1'b0; // RULE15
        end else if (is_p2p) begin
            state_next.latched = 1'b0;
            if (fall) begin
                state_next.have_ext = 1'b0; // RULE16
            end
            if (!timing_in && sample_valid) begin
                state_next.max_v = max_n; // RULE1
                state_next.min_v = min_n;
                state_next.have_ext = 1'b1;
            end
            if (!is_cont) begin
                if (rise && state_reg.have_ext) begin
                    state_next.disp = diff_hold; // RULE2
                    {state_next.high, state_next.go, state_next.low} =
                        {jif.high, jif.go, jif.low}; // RULE17
                    state_next.valid = 1'b1;
                end
            end else begin
                if (fall) begin
                    state_next.disp = '0; // RULE3
                    {state_next.high, state_next.go, state_next.low} = 3'h0;
                end
                // Difference only grows in a window, so the last one is the largest
                if (!timing_in && sample_valid) begin
                    state_next.disp = diff_n; // RULE4
                    {state_next.high, state_next.go, state_next.low} =
                        {jif.high, jif.go, jif.low};
                    state_next.valid = 1'b1;
                end
                // While timing is on nothing is touched, so the window result stays RULE5
            end
        end else begin
            if (fall) begin
                state_next.latched = 1'b0; // RULE12
                {state_next.high, state_next.go, state_next.low} = 3'h0;
            end
            if (!timing_in) begin
                if (sample_valid) begin
                    state_next.disp = sample_ext; // RULE7
                    state_next.valid = 1'b1;
                    if (!state_next.latched) begin
                        {state_next.high, state_next.go, state_next.low} =
                            {jif.high, jif.go, jif.low};
                        if (jif.high || jif.low) begin
                            state_next.latched = 1'b1; // RULE9 RULE14
                        end
                    end
                end
            end else if (rise) begin
                state_next.disp = sample_ext; // RULE11
                state_next.valid = 1'b1;
                if (!state_reg.latched) begin
                    {state_next.high, state_next.go, state_next.low} = 3'h2; // RULE8
                end
            end
            // Timing held on: display and criterion stay, latch included RULE6 RULE10
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign display_value = state_reg.disp;
    assign display_valid = state_reg.valid;
    assign high_out = state_reg.high;
    assign go_out = state_reg.go;
    assign low_out = state_reg.low;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_one_hot;
        $onehot0({high_out, go_out, low_out});
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("more than one criterion output"); // RULE17

    property p_track;
        (is_p2p && !timing_in && sample_valid && !reset_in && !fall && state_reg.have_ext)
            |=> (state_reg.max_v >= $past(sample_value))
                && (state_reg.min_v <= $past(sample_value));
    endproperty
    a_track: assert property (p_track) else $error("extremes not tracked"); // RULE1

    property p_edge_update;
        (is_p2p && !is_cont && rise && state_reg.have_ext && !reset_in)
            |=> display_value == $past(diff_hold);
    endproperty
    a_edge_update: assert property (p_edge_update) else $error("edge result wrong"); // RULE2

    property p_cont_clear;
        (is_p2p && is_cont && fall && !sample_valid && !reset_in)
            |=> (display_value == '0) && !high_out && !go_out && !low_out;
    endproperty
    a_cont_clear: assert property (p_cont_clear) else $error("display not cleared"); // RULE3

    property p_cont_refresh;
        (is_p2p && is_cont && !timing_in && sample_valid && !reset_in)
            |=> display_value == $past(diff_n);
    endproperty
    a_cont_refresh: assert property (p_cont_refresh) else $error("display not refreshed"); // RULE4

    property p_cont_freeze;
        (is_p2p && is_cont && timing_in && state_reg.timing_d && !reset_in)
            |=> $stable(display_value) && $stable(high_out) && $stable(go_out);
    endproperty
    a_cont_freeze: assert property (p_cont_freeze) else $error("frozen value moved"); // RULE5

    property p_ng_hold;
        (!is_p2p && timing_in && state_reg.timing_d && !reset_in)
            |=> $stable(display_value) && $stable(high_out)
                && $stable(low_out) && $stable(go_out);
    endproperty
    a_ng_hold: assert property (p_ng_hold) else $error("held result moved"); // RULE6

    property p_ng_live;
        (!is_p2p && !timing_in && sample_valid && !reset_in)
            |=> display_value == $past(sample_ext);
    endproperty
    a_ng_live: assert property (p_ng_live) else $error("live value not shown"); // RULE7

    property p_ng_go;
        (!is_p2p && rise && !state_reg.latched && !reset_in) |=> go_out && !high_out && !low_out;
    endproperty
    a_ng_go: assert property (p_ng_go) else $error("GO not held"); // RULE8

    property p_high_latch;
        (!is_p2p && state_reg.latched && high_out && !fall && !reset_in) |=> high_out;
    endproperty
    a_high_latch: assert property (p_high_latch) else $error("HIGH latch lost"); // RULE9

    property p_low_latch;
        (!is_p2p && state_reg.latched && low_out && !fall && !reset_in) |=> low_out;
    endproperty
    a_low_latch: assert property (p_low_latch) else $error("LOW latch lost"); // RULE14

    property p_ng_capture;
        (!is_p2p && rise && !reset_in) |=> display_value == $past(sample_ext);
    endproperty
    a_ng_capture: assert property (p_ng_capture) else $error("edge value not captured"); // RULE11

    property p_release;
        (!is_p2p && fall && !sample_valid && !reset_in) |=> !high_out && !go_out && !low_out;
    endproperty
    a_release: assert property (p_release) else $error("hold not released"); // RULE12

    property p_reset_high;
        reset_in |=> !high_out && !state_reg.latched;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("HIGH not cleared"); // RULE13

    property p_reset_low;
        reset_in |=> !low_out && !display_valid;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("LOW not cleared"); // RULE15

    c_p2p_edge: cover property (is_p2p && !is_cont && rise && state_reg.have_ext);
    c_cont_window: cover property (is_p2p && is_cont && fall ##[1:20] rise);
    c_high_latched: cover property (!is_p2p && high_out && rise);
    c_low_latched: cover property (!is_p2p && low_out && rise);

endmodule

// ---- design/hold_pkg.sv ----
package hold_pkg;

    // ------------------------------------------------------------------
    // Widths and limits
    // ------------------------------------------------------------------
    localparam int DATA_W_DEF = 16;    // Default width of a live sample
    localparam int DATA_W_MIN = 2;     // Narrowest sample the logic serves
    localparam int DATA_W_MAX = 30;    // Widest sample the logic serves

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_TIMING = 1'b1;    // Timing input assumed at rest (on), no false rise
    localparam logic RST_FLAG = 1'b0;      // Flags and criterion outputs off

    // ------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------
    typedef enum logic {
        MODE_P2P = 1'b0,    // Peak-to-peak judgment
        MODE_NG_HOLD = 1'b1 // Out-of-tolerance hold
    } mode_t;

    typedef enum logic {
        UPD_TIMING = 1'b0,  // Update at the end of the window
        UPD_CONT = 1'b1     // Update on every sample of the window
    } upd_t;

endpackage

// ---- design/judge_if.sv ----
`timescale 1ns/1ps
// Carries a value to the comparator and the three criterion bits back
interface judge_if #(
    parameter int W = 17
);
    logic signed [W-1:0] value;
    logic signed [W-1:0] upper;
    logic signed [W-1:0] lower;
    logic high;
    logic go;
    logic low;

    modport judge (input value, input upper, input lower, output high, output go, output low);
    modport user (output value, output upper, output lower, input high, input go, input low);
endinterface

// ---- design/judge_unit.sv ----
`timescale 1ns/1ps
module judge_unit (
    judge_if.judge jif // Value and setpoints in, criterion bits out
);

    // ------------------------------------------------------------------
    // Comparison
    // ------------------------------------------------------------------
    // Returns {high, go, low}; exactly one bit is set
    function automatic logic [2:0] classify(input logic above, input logic below);
        logic [2:0] r;
        r = 3'h2;
        if (above) begin
            r = 3'h4;
        end else if (below) begin
            r = 3'h1;
        end
        return r;
    endfunction

    // Upper setpoint wins if the setpoints cross
    always_comb begin
        {jif.high, jif.go, jif.low} = classify(jif.value > jif.upper, jif.value < jif.lower);
    end

endmodule

// ---- tb/ctrl_model.sv ----
`timescale 1ns/1ps
// Outside controller: drives the timing and reset inputs of the judgment logic
module ctrl_model (
    input wire logic core_clk,  // System clock
    output logic timing_in,     // Timing input, high is on
    output logic reset_in       // Reset input, high clears
);
    // ------------------------------------------------------------------
    // Rest levels: timing on between windows, reset off
    // ------------------------------------------------------------------
    initial begin
        timing_in = 1'b1;
        reset_in = 1'b0;
    end

    // Move the timing level after a gap of whole cycles, so slow controllers fit too
    task automatic set_timing(input logic lvl, input int gap);
        repeat (gap) @(posedge core_clk);
        #1 timing_in = lvl;
    endtask

    // One-cycle reset pulse that releases a latched criterion early
    task automatic pulse_reset();
        @(posedge core_clk);
        #1 reset_in = 1'b1;
        @(posedge core_clk);
        #1 reset_in = 1'b0;
    endtask
endmodule

// ---- tb/tb_hold_judgment_logic.sv ----
`timescale 1ns/1ps
// Compare two values, count the check, report a miss at once
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp); end end

module tb_hold_judgment_logic;
    import hold_pkg::*;
    localparam int DW = 16;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic core_clk;
    logic rst_n;
    logic timing_in;
    logic reset_in;
    mode_t detect_mode;
    upd_t hold_update_select;
    logic sample_valid;
    logic signed [DW-1:0] sample_value;
    logic signed [DW:0] upper_setpoint;
    logic signed [DW:0] lower_setpoint;
    logic signed [DW:0] display_value;
    logic display_valid;
    logic high_out;
    logic go_out;
    logic low_out;
    int n_errors;
    int checked;

    hold_judgment_logic #(.DATA_W(DW)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .timing_in(timing_in), .reset_in(reset_in),
        .detect_mode(detect_mode), .hold_update_select(hold_update_select),
        .sample_valid(sample_valid), .sample_value(sample_value),
        .upper_setpoint(upper_setpoint), .lower_setpoint(lower_setpoint),
        .display_value(display_value), .display_valid(display_valid),
        .high_out(high_out), .go_out(go_out), .low_out(low_out)
    );

    ctrl_model u_ctrl (.core_clk(core_clk), .timing_in(timing_in), .reset_in(reset_in));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Wait edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One strobed sample, with a quiet cycle after it
    task automatic smp(input logic signed [DW-1:0] v);
        sample_value = v;
        sample_valid = 1'b1;
        tick(1);
        sample_valid = 1'b0;
        tick(1);
    endtask

    // Display value and criterion triple {high, go, low}
    task automatic chk_out(input logic signed [DW:0] d, input logic [2:0] c);
        `CHK(display_value, d)
        `CHK({high_out, go_out, low_out}, c)
    endtask

    // Window of three samples; display must wait for the rise, then show the difference
    task automatic p2p_win(input logic signed [DW-1:0] a, input logic signed [DW-1:0] b,
                           input logic signed [DW-1:0] c, input logic signed [DW:0] prev,
                           input logic signed [DW:0] d, input logic [2:0] crit);
        u_ctrl.set_timing(1'b0, 1);
        smp(a);
        smp(b);
        smp(c);
        tick(2);
        `CHK(display_value, prev)
        u_ctrl.set_timing(1'b1, 1);
        tick(2);
        chk_out(d, crit);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Peak-to-peak judged at the end of each window, all three criteria
    task automatic test_p2p_timing();
        detect_mode = MODE_P2P;
        hold_update_select = UPD_TIMING;
        p2p_win(16'sh000a, 16'sh0050, -16'sh001e, 17'sh00000, 17'sh0006e, 3'b100);
        `CHK(display_valid, 1'b1)
        p2p_win(16'sh0005, 16'sh0032, 16'sh0014, 17'sh0006e, 17'sh0002d, 3'b010);
        lower_setpoint = 17'sh00014;
        p2p_win(16'sh0064, 16'sh006e, 16'sh0069, 17'sh0002d, 17'sh0000a, 3'b001);
        lower_setpoint = -17'sh00064;
        $display("test p2p_timing done");
    endtask

    // Continuous update: clear at window start, refresh per sample, freeze at rise
    task automatic test_p2p_cont();
        hold_update_select = UPD_CONT;
        u_ctrl.set_timing(1'b0, 2);
        tick(2);
        chk_out(17'sh00000, 3'b000);
        smp(16'sh0000);
        smp(16'sh0028);
        chk_out(17'sh00028, 3'b010);
        smp(16'sh0096);
        chk_out(17'sh00096, 3'b100);
        u_ctrl.set_timing(1'b1, 1);
        tick(1);
        smp(-16'sh00c8);
        chk_out(17'sh00096, 3'b100);
        $display("test p2p_cont done");
    endtask

    // Hold mode with no out-of-tolerance result: GO held, captured display
    task automatic test_ng_go();
        detect_mode = MODE_NG_HOLD;
        u_ctrl.set_timing(1'b0, 1);
        smp(16'sh001e);
        chk_out(17'sh0001e, 3'b010);
        sample_value = 16'sh0037;
        u_ctrl.set_timing(1'b1, 1);
        tick(2);
        chk_out(17'sh00037, 3'b010);
        smp(16'sh01f4);
        chk_out(17'sh00037, 3'b010);
        u_ctrl.set_timing(1'b0, 1);
        tick(2);
        `CHK({high_out, go_out, low_out}, 3'b000)
        $display("test ng_go done");
    endtask

    // HIGH latches in the window, survives the rise, cleared by the reset input
    task automatic test_ng_high();
        smp(16'sh00c8);
        `CHK(high_out, 1'b1)
        smp(16'sh0000);
        chk_out(17'sh00000, 3'b100);
        u_ctrl.set_timing(1'b1, 1);
        tick(3);
        chk_out(17'sh00000, 3'b100);
        u_ctrl.pulse_reset();
        tick(2);
        `CHK({high_out, go_out, low_out}, 3'b000)
        `CHK(display_valid, 1'b0)
        $display("test ng_high done");
    endtask

    // LOW latches the same way and is cleared by the reset input
    task automatic test_ng_low();
        u_ctrl.set_timing(1'b0, 1);
        smp(-16'sh00c8);
        smp(16'sh0000);
        `CHK({high_out, go_out, low_out}, 3'b001)
        u_ctrl.set_timing(1'b1, 1);
        tick(2);
        `CHK(low_out, 1'b1)
        u_ctrl.pulse_reset();
        tick(2);
        `CHK(low_out, 1'b0)
        $display("test ng_low done");
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    // Counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence after a 12-cycle reset
    initial begin
        n_errors = 0;
        checked = 0;
        rst_n = 1'b0;
        sample_valid = 1'b0;
        sample_value = 16'sh0000;
        upper_setpoint = 17'sh00064;
        lower_setpoint = -17'sh00064;
        detect_mode = MODE_P2P;
        hold_update_select = UPD_TIMING;
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1'b1;
        tick(1);
        test_p2p_timing();
        test_p2p_cont();
        test_ng_go();
        test_ng_high();
        test_ng_low();
        stop_test();
    end

    // Watchdog: the tests take well under 300 cycles
    initial begin
        #20000;
        n_errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
